// File: logic/cirs_pkg.sv
// Shared constants and types for the codec two-wire register port
package cirs_pkg;

	// ----------------------------------------
	// Addressing and register file
	// ----------------------------------------
	localparam logic [5:0] CIRS_ADDR_HIGH = 6'h08;
	localparam int REG_COUNT = 80;
	localparam int REG_BITS = 8 * REG_COUNT;
	localparam logic [7:0] REG_LAST_INDEX = 8'h4f;
	// Byte n of this vector is the value of register n after reset
	localparam logic [REG_BITS-1:0] CIRS_REG_DEFAULTS = {
		128'h000000fffdf71ffffdf71ffffdf71fff,
		128'hfdf71ffffdf71ffffdf71fc0c0000010,
		128'h11000332b0001c00c010080100c00000,
		128'h8080000f03220688000033000028fc01,
		128'h00003ff8000001000011001120000303
	};

	// ----------------------------------------
	// Bit framing
	// ----------------------------------------
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;

	// ----------------------------------------
	// Link timing on the host side
	// ----------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int LINK_RATE_KBPS = 400;
	localparam int QUARTERS_PER_BIT = 4;
	// Least quarter-bit time, rounded up so the rate never exceeds the limit
	localparam int QUARTER_CYCLES = (CLK_HZ + QUARTERS_PER_BIT * LINK_RATE_KBPS * 1000 - 1)
		/ (QUARTERS_PER_BIT * LINK_RATE_KBPS * 1000);
	localparam logic [7:0] QUARTER_RELOAD = 8'(QUARTER_CYCLES - 1);
	localparam logic [7:0] TIMER_RESET = 8'h00;

	// ----------------------------------------
	// Host transfer sequence positions
	// ----------------------------------------
	localparam logic [1:0] POS_ADDR = 2'h0;
	localparam logic [1:0] POS_INDEX = 2'h1;
	localparam logic [1:0] POS_THIRD = 2'h2;
	localparam logic [1:0] POS_RDATA = 2'h3;

	typedef enum logic [4:0] {
		DEV_IDLE = 5'b00001,
		DEV_ADDR = 5'b00010,
		DEV_INDEX = 5'b00100,
		DEV_WRITE = 5'b01000,
		DEV_READ = 5'b10000
	} cirs_dev_state_e;

	typedef enum logic [3:0] {
		HOST_IDLE = 4'b0001,
		HOST_START = 4'b0010,
		HOST_BIT = 4'b0100,
		HOST_STOP = 4'b1000
	} cirs_host_state_e;

endpackage

// File: logic/cirs_link_if.sv
// Two-wire link between bus master and codec register port
`timescale 1ns/10ps
interface cirs_link_if;
	logic scl;
	logic hostSdaOut;
	logic hostSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	logic sda;

	// Open-drain data wire with pull-up
	assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

	modport host(output scl, output hostSdaOut, output hostSdaOe, input sda);
	modport device(input scl, input sda, output devSdaOut, output devSdaOe);
endinterface

// File: logic/cirs_device.sv
// Codec end of the two-wire register port, clocked by the link clock
//
// How it works
// - Bytes go MSB first, sampled while clock high
// - Receiver pulls data low in ninth bit; the host leaves it high after read data
// - Link runs at up to 400 kbps
// - Falling data with clock high starts transfer
// - Rising data with clock high returns idle
// - First byte: seven-bit address plus direction
// - Answer only 001000 plus address-select pin level
// - Following bytes flow in the chosen direction
// - Write: address, index, data, each acknowledged
// - Read: write index first, then readdress reading
// - Read phase returns the indexed register contents
// - Every register writable and readable over link
`timescale 1ns/10ps
module cirs_device
	import cirs_pkg::*;
(
	cirs_link_if.device link,
	input logic resetn,
	input logic addrSelectPin,
	output logic [REG_BITS-1:0] cfgRegs,
	output logic cfgWriteToggle
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	cirs_dev_state_e state_q;
	cirs_dev_state_e nextState_q;
	logic startTog_q;
	logic stopTog_q;
	logic startSeen_q;
	logic stopSeen_q;
	logic [3:0] bitCnt_q;
	logic [7:0] shift_q;
	logic [7:0] index_q;
	logic ackMe_q;
	logic sdaOe_q;
	logic writeTog_q;
	logic addrSelMeta_q;
	logic addrSel_q;
	logic [7:0] regs_q [0:REG_COUNT-1];

	logic startNew;
	logic stopNew;
	logic inFrame;
	logic dataSlot;
	logic ackSlot;
	logic byteDone;
	logic [7:0] newByte;
	logic addrHit;
	logic indexInRange;
	logic regWrite;
	logic [7:0] readByte;
	logic [2:0] txBitSel;
	logic readBitLow;
	logic rxAckLow;
	logic driveLow;
	logic isReceiver;

	// ----------------------------------------
	// Start and stop detection
	// ----------------------------------------
	// Data edges only mean start or stop while the clock is high; the
	// master moves data only with the clock low, so these never fire mid-byte.
	always_ff @(negedge link.sda or negedge resetn) begin
		if (!resetn) begin
			startTog_q <= 1'b0;
		end else if (link.scl) begin
			startTog_q <= ~startTog_q;
		end
	end

	always_ff @(posedge link.sda or negedge resetn) begin
		if (!resetn) begin
			stopTog_q <= 1'b0;
		end else if (link.scl) begin
			stopTog_q <= ~stopTog_q;
		end
	end

	// Toggles settle a whole clock-low phase before the next rising edge
	assign startNew = startTog_q ^ startSeen_q;
	assign stopNew = stopTog_q ^ stopSeen_q;

	// ----------------------------------------
	// Byte decode
	// ----------------------------------------
	assign inFrame = !startNew && !stopNew && (state_q != DEV_IDLE);
	assign dataSlot = inFrame && (bitCnt_q != ACK_SLOT);
	assign ackSlot = inFrame && (bitCnt_q == ACK_SLOT);
	assign byteDone = dataSlot && (bitCnt_q == BIT_LAST);
	assign newByte = {shift_q[6:0], link.sda};
	assign addrHit = (newByte[7:1] == {CIRS_ADDR_HIGH, addrSel_q});
	assign indexInRange = (index_q <= REG_LAST_INDEX);
	assign regWrite = byteDone && (state_q == DEV_WRITE) && indexInRange;
	assign isReceiver = (state_q == DEV_ADDR) || (state_q == DEV_INDEX) || (state_q == DEV_WRITE);

	// Indexes past the last register read as zero and ignore writes
	assign readByte = indexInRange ? regs_q[index_q[6:0]] : 8'h00;

	// ----------------------------------------
	// Receive and sequence, rising clock edge
	// ----------------------------------------
	// Pure edge-driven logic: any bit rate the master keeps to works.
	always_ff @(posedge link.scl or negedge resetn) begin
		if (!resetn) begin
			startSeen_q <= 1'b0;
			stopSeen_q <= 1'b0;
		end else begin
			startSeen_q <= startTog_q;
			stopSeen_q <= stopTog_q;
		end
	end

	// Strap pin is not on the link clock; two stages before the compare.
	// Settles within the address byte, so the pin may change between frames.
	always_ff @(posedge link.scl or negedge resetn) begin
		if (!resetn) begin
			addrSelMeta_q <= 1'b0;
			addrSel_q <= 1'b0;
		end else begin
			addrSelMeta_q <= addrSelectPin;
			addrSel_q <= addrSelMeta_q;
		end
	end

	always_ff @(posedge link.scl or negedge resetn) begin
		if (!resetn) begin
			state_q <= DEV_IDLE;
			bitCnt_q <= BIT_FIRST;
			shift_q <= 8'h00;
		end else if (startNew) begin
			state_q <= DEV_ADDR;
			bitCnt_q <= BIT_FIRST + 4'h1;
			shift_q <= {7'h00, link.sda};
		end else if (stopNew || (state_q == DEV_IDLE)) begin
			state_q <= DEV_IDLE;
		end else if (dataSlot) begin
			shift_q <= newByte;
			bitCnt_q <= bitCnt_q + 4'h1;
		end else begin
			bitCnt_q <= BIT_FIRST;
			if (state_q == DEV_READ) begin
				// Master not acknowledging ends the read
				state_q <= link.sda ? DEV_IDLE : DEV_READ;
			end else begin
				state_q <= nextState_q;
			end
		end
	end

	// Decision on each completed byte, acted on at its ninth clock
	always_ff @(posedge link.scl or negedge resetn) begin
		if (!resetn) begin
			nextState_q <= DEV_IDLE;
			ackMe_q <= 1'b0;
		end else if (byteDone) begin
			case (state_q)
				DEV_ADDR: begin
					ackMe_q <= addrHit;
					if (!addrHit) begin
						nextState_q <= DEV_IDLE;
					end else if (link.sda == DIR_READ) begin
						nextState_q <= DEV_READ;
					end else begin
						nextState_q <= DEV_INDEX;
					end
				end
				DEV_INDEX: begin
					ackMe_q <= 1'b1;
					nextState_q <= DEV_WRITE;
				end
				DEV_WRITE: begin
					ackMe_q <= 1'b1;
					nextState_q <= DEV_WRITE;
				end
				default: begin
					ackMe_q <= 1'b0;
					nextState_q <= DEV_IDLE;
				end
			endcase
		end
	end

	// Register index: set by the index byte, advanced after each written byte and each read byte the master acknowledges
	always_ff @(posedge link.scl or negedge resetn) begin
		if (!resetn) begin
			index_q <= 8'h00;
		end else if (byteDone && (state_q == DEV_INDEX)) begin
			index_q <= newByte;
		end else if (byteDone && (state_q == DEV_WRITE)) begin
			index_q <= index_q + 8'h01;
		end else if (ackSlot && (state_q == DEV_READ) && !link.sda) begin
			index_q <= index_q + 8'h01;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge link.scl or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_q[i] <= CIRS_REG_DEFAULTS[i*8 +: 8];
			end
		end else if (regWrite) begin
			regs_q[index_q[6:0]] <= newByte;
		end
	end

	// Toggle per stored byte lets system-clock logic see updates safely
	always_ff @(posedge link.scl or negedge resetn) begin
		if (!resetn) begin
			writeTog_q <= 1'b0;
		end else if (regWrite) begin
			writeTog_q <= ~writeTog_q;
		end
	end

	for (genvar g = 0; g < REG_COUNT; g++) begin : gFlat
		assign cfgRegs[g*8 +: 8] = regs_q[g];
	end
	assign cfgWriteToggle = writeTog_q;

	// ----------------------------------------
	// Data line drive, falling clock edge
	// ----------------------------------------
	// Changing only with the clock low keeps the device from ever faking
	// a start or stop of its own.
	assign txBitSel = 3'(BIT_LAST - bitCnt_q);
	assign readBitLow = (state_q == DEV_READ) && (bitCnt_q != ACK_SLOT) && !readByte[txBitSel];
	assign rxAckLow = isReceiver && (bitCnt_q == ACK_SLOT) && ackMe_q;
	assign driveLow = readBitLow || rxAckLow;

	always_ff @(negedge link.scl or negedge resetn) begin
		if (!resetn) begin
			sdaOe_q <= 1'b0;
		end else begin
			sdaOe_q <= driveLow;
		end
	end

	assign link.devSdaOe = sdaOe_q;
	assign link.devSdaOut = 1'b0;

endmodule

// File: logic/cirs_host.sv
// Bus master end: issues register writes and reads over the two-wire link
`timescale 1ns/10ps
module cirs_host
	import cirs_pkg::*;
(
	input logic clk,
	input logic resetn,
	cirs_link_if.host link,
	input logic reqValid,
	input logic reqRead,
	input logic [6:0] reqSlave,
	input logic [7:0] reqIndex,
	input logic [7:0] reqData,
	output logic reqReady,
	output logic doneValid,
	output logic doneNack,
	output logic [7:0] doneData
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	cirs_host_state_e state_q;
	logic [1:0] quarter_q;
	logic [7:0] timer_q;
	logic [3:0] bitCnt_q;
	logic [1:0] bytePos_q;
	logic isRead_q;
	logic [6:0] slave_q;
	logic [7:0] index_q;
	logic [7:0] wdata_q;
	logic [7:0] rx_q;
	logic ackBit_q;
	logic sdaMeta_q;
	logic sdaSync_q;
	logic scl_q;
	logic sdaOe_q;
	logic ready_q;
	logic done_q;
	logic nack_q;
	logic [7:0] doneData_q;

	logic tick;
	logic ackSlot;
	logic readByte;
	logic lastByte;
	logic restartNext;
	logic [7:0] txByte;
	logic [2:0] bitSel;
	logic bitDrive;

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sdaMeta_q <= 1'b1;
			sdaSync_q <= 1'b1;
		end else begin
			sdaMeta_q <= link.sda;
			sdaSync_q <= sdaMeta_q;
		end
	end

	// ----------------------------------------
	// Byte selection
	// ----------------------------------------
	assign tick = (timer_q == TIMER_RESET);
	assign ackSlot = (bitCnt_q == ACK_SLOT);
	assign readByte = isRead_q && (bytePos_q == POS_RDATA);
	assign lastByte = isRead_q ? (bytePos_q == POS_RDATA) : (bytePos_q == POS_THIRD);
	assign restartNext = isRead_q && (bytePos_q == POS_INDEX);
	assign txByte = (bytePos_q == POS_ADDR) ? {slave_q, DIR_WRITE} :
		(bytePos_q == POS_INDEX) ? index_q :
		(isRead_q ? {slave_q, DIR_READ} : wdata_q);
	assign bitSel = 3'(BIT_LAST - bitCnt_q);
	// Ack slots and read data are released; the far end answers, except the ack after read data, left high
	assign bitDrive = !ackSlot && !readByte && !txByte[bitSel];

	// ----------------------------------------
	// Quarter-bit sequencer
	// ----------------------------------------
	// Each bit spans four quarters: set data, raise clock, sample, drop clock.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= HOST_IDLE;
			quarter_q <= 2'h0;
			timer_q <= TIMER_RESET;
			bitCnt_q <= BIT_FIRST;
			bytePos_q <= POS_ADDR;
			scl_q <= 1'b1;
			sdaOe_q <= 1'b0;
			ackBit_q <= 1'b1;
			rx_q <= 8'h00;
		end else if (state_q == HOST_IDLE) begin
			if (reqValid) begin
				state_q <= HOST_START;
				quarter_q <= 2'h0;
				timer_q <= QUARTER_RELOAD;
				bytePos_q <= POS_ADDR;
			end
		end else if (!tick) begin
			timer_q <= timer_q - 8'h01;
		end else begin
			timer_q <= QUARTER_RELOAD;
			quarter_q <= quarter_q + 2'h1;
			case (state_q)
				HOST_START: begin
					case (quarter_q)
						2'h0: sdaOe_q <= 1'b0;
						2'h1: scl_q <= 1'b1;
						2'h2: sdaOe_q <= 1'b1;
						default: begin
							scl_q <= 1'b0;
							state_q <= HOST_BIT;
							bitCnt_q <= BIT_FIRST;
						end
					endcase
				end
				HOST_BIT: begin
					case (quarter_q)
						2'h0: sdaOe_q <= bitDrive;
						2'h1: scl_q <= 1'b1;
						2'h2: begin
							if (ackSlot) begin
								ackBit_q <= sdaSync_q;
							end else if (readByte) begin
								rx_q <= {rx_q[6:0], sdaSync_q};
							end
						end
						default: begin
							scl_q <= 1'b0;
							if (!ackSlot) begin
								bitCnt_q <= bitCnt_q + 4'h1;
							end else if ((!readByte && ackBit_q) || lastByte) begin
								state_q <= HOST_STOP;
							end else if (restartNext) begin
								bytePos_q <= POS_THIRD;
								state_q <= HOST_START;
							end else begin
								bytePos_q <= bytePos_q + 2'h1;
								bitCnt_q <= BIT_FIRST;
							end
						end
					endcase
				end
				HOST_STOP: begin
					case (quarter_q)
						2'h0: sdaOe_q <= 1'b1;
						2'h1: scl_q <= 1'b1;
						2'h2: sdaOe_q <= 1'b0;
						default: state_q <= HOST_IDLE;
					endcase
				end
				default: state_q <= HOST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Request latch and completion
	// ----------------------------------------
	logic acceptReq;
	logic finishNow;
	logic nackNow;
	assign acceptReq = (state_q == HOST_IDLE) && reqValid;
	assign finishNow = (state_q == HOST_STOP) && tick && (quarter_q == 2'h3);
	assign nackNow = (state_q == HOST_BIT) && tick && (quarter_q == 2'h3) && ackSlot && !readByte && ackBit_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			isRead_q <= 1'b0;
			slave_q <= 7'h00;
			index_q <= 8'h00;
			wdata_q <= 8'h00;
		end else if (acceptReq) begin
			isRead_q <= reqRead;
			slave_q <= reqSlave;
			index_q <= reqIndex;
			wdata_q <= reqData;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ready_q <= 1'b1;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			doneData_q <= 8'h00;
		end else begin
			done_q <= finishNow;
			if (acceptReq) begin
				ready_q <= 1'b0;
				nack_q <= 1'b0;
			end else if (finishNow) begin
				ready_q <= 1'b1;
				doneData_q <= rx_q;
			end
			if (nackNow) begin
				nack_q <= 1'b1;
			end
		end
	end

	assign reqReady = ready_q;
	assign doneValid = done_q;
	assign doneNack = nack_q;
	assign doneData = doneData_q;
	assign link.scl = scl_q;
	assign link.hostSdaOe = sdaOe_q;
	assign link.hostSdaOut = 1'b0;

endmodule

// File: dv/cirs_link_chk.sv
// Link checker: framing, acknowledge and release on the two-wire link
`timescale 1ns/10ps
module cirs_link_chk
	import cirs_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic hostSdaOut,
	input wire logic hostSdaOe,
	input wire logic devSdaOut,
	input wire logic devSdaOe,
	input wire logic sda,
	input wire logic addrSelectPin
);
	// ----------------------------------------
	// Bit tracking
	// ----------------------------------------
	logic sclPrev_q;
	logic sdaPrev_q;
	logic firstByte_q;
	logic rdPhase_q;
	logic [7:0] sclRun_q;
	logic [7:0] shift_q;
	logic [3:0] bitPos_q;
	wire logic sclRise = scl && !sclPrev_q;
	wire logic startSeen = scl && sclPrev_q && sdaPrev_q && !sda;
	wire logic ackRise = sclRise && (bitPos_q == ACK_SLOT);
	wire logic addrHit = shift_q[7:1] == {CIRS_ADDR_HIGH, addrSelectPin};

	// Idle levels at reset so the first edges after release see no false change
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
			sclRun_q <= 8'h00;
			shift_q <= 8'h00;
			bitPos_q <= BIT_FIRST;
			firstByte_q <= 1'b0;
			rdPhase_q <= 1'b0;
		end else begin
			sclPrev_q <= scl;
			sdaPrev_q <= sda;
			sclRun_q <= (scl != sclPrev_q) ? 8'h00 : sclRun_q + {7'h00, sclRun_q != 8'hff};
			if (startSeen) begin
				bitPos_q <= BIT_FIRST;
				firstByte_q <= 1'b1;
				rdPhase_q <= 1'b0;
			end else if (sclRise) begin
				shift_q <= {shift_q[6:0], sda};
				bitPos_q <= ackRise ? BIT_FIRST : bitPos_q + 4'h1;
				if (firstByte_q && bitPos_q == BIT_LAST)
					rdPhase_q <= sda;
				if (ackRise)
					firstByte_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence sStop;
		scl && sclPrev_q && !sdaPrev_q && sda;
	endsequence
	sequence sIdle;
		(scl && sda && !devSdaOe) [*8];
	endsequence

	property p_sclHalf;
		(scl != sclPrev_q) |-> sclRun_q >= 8'h18;
	endproperty
	property p_devQuietHigh;
		scl && sclPrev_q |-> $stable(devSdaOe);
	endproperty
	property p_ackSlot;
		sclRise && devSdaOe && !rdPhase_q |-> bitPos_q == ACK_SLOT;
	endproperty
	property p_addrListen;
		sclRise && firstByte_q && bitPos_q != ACK_SLOT |-> !devSdaOe;
	endproperty
	property p_addrHit;
		ackRise && firstByte_q && addrHit |-> devSdaOe;
	endproperty
	property p_addrMiss;
		ackRise && firstByte_q && !addrHit |-> !devSdaOe [*8];
	endproperty
	property p_oneSender;
		devSdaOe && scl |-> !hostSdaOe && !hostSdaOut && !devSdaOut;
	endproperty
	property p_stopIdle;
		sStop |-> sIdle;
	endproperty

	a_sclHalf: assert property (p_sclHalf) else $error("Clock half period too short");
	a_devQuietHigh: assert property (p_devQuietHigh) else $error("Device changed data while clock high");
	a_ackSlot: assert property (p_ackSlot) else $error("Device drove outside acknowledge slot");
	a_addrListen: assert property (p_addrListen) else $error("Device drove during address bits");
	a_addrHit: assert property (p_addrHit) else $error("Own address not acknowledged");
	a_addrMiss: assert property (p_addrMiss) else $error("Foreign address acknowledged");
	a_oneSender: assert property (p_oneSender) else $error("Both ends send at once");
	a_stopIdle: assert property (p_stopIdle) else $error("Link not idle after stop");
endmodule

// File: dv/codec_i2c_register_access_slave_tb_top.sv
// Bench: bus master and register port joined over the two-wire link
`timescale 1ns/10ps
module codec_i2c_register_access_slave_tb_top
	import cirs_pkg::*;
;
	// ----------------------------------------
	// Harness
	// ----------------------------------------
	logic clk = 1'b0;
	// Starts high so its fall is an edge every asynchronous flop sees
	logic resetn = 1'b1;
	logic addrSelectPin = 1'b0;
	logic reqValid = 1'b0;
	logic reqRead = 1'b0;
	logic [6:0] reqSlave = 7'h00;
	logic [7:0] reqIndex = 8'h00;
	logic [7:0] reqData = 8'h00;
	logic reqReady;
	logic doneValid;
	logic doneNack;
	logic [7:0] doneData;
	logic [REG_BITS-1:0] cfgRegs;
	logic cfgWriteToggle;
	logic rxNack;
	logic [7:0] rxData;
	int failCount = 0;
	int comparisons = 0;
	int cycles = 0;
	int busyCycles = 0;
	localparam logic [7:0] IDX_TAB [4] = '{8'h00, 8'h2a, 8'h4f, 8'h50};

	cirs_link_if i_cirs_link_if();
	cirs_host i_cirs_host(.clk(clk), .resetn(resetn), .link(i_cirs_link_if), .reqValid(reqValid),
		.reqRead(reqRead), .reqSlave(reqSlave), .reqIndex(reqIndex), .reqData(reqData), .reqReady(reqReady),
		.doneValid(doneValid), .doneNack(doneNack), .doneData(doneData));
	cirs_device i_cirs_device(.link(i_cirs_link_if), .resetn(resetn), .addrSelectPin(addrSelectPin),
		.cfgRegs(cfgRegs), .cfgWriteToggle(cfgWriteToggle));
	cirs_link_chk i_cirs_link_chk(.clk(clk), .resetn(resetn), .scl(i_cirs_link_if.scl),
		.hostSdaOut(i_cirs_link_if.hostSdaOut), .hostSdaOe(i_cirs_link_if.hostSdaOe),
		.devSdaOut(i_cirs_link_if.devSdaOut), .devSdaOe(i_cirs_link_if.devSdaOe), .sda(i_cirs_link_if.sda),
		.addrSelectPin(addrSelectPin));

	always #25 clk = ~clk;

	// Whole run needs about 35k cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 50000) begin
			failCount++;
			endOfTest();
		end
	end

	task endOfTest;
		$display("Mismatches %0d, comparisons %0d", failCount, comparisons);
		if (failCount == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failCount++;
			$display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask

	// One request; returns once the done pulse is seen or the bound runs out
	task xfer(input logic rd, input logic [6:0] slave, input logic [7:0] idx, input logic [7:0] data);
		int n;
		@(negedge clk);
		while (reqReady !== 1'b1) @(negedge clk);
		reqValid = 1'b1;
		reqRead = rd;
		reqSlave = slave;
		reqIndex = idx;
		reqData = data;
		@(negedge clk);
		reqValid = 1'b0;
		check({7'h00, reqReady}, 8'h00);
		n = 0;
		while (doneValid !== 1'b1 && n < 2200) begin
			@(negedge clk);
			n++;
		end
		check({7'h00, doneValid}, 8'h01);
		check({7'h00, reqReady}, 8'h01);
		busyCycles = n;
		rxNack = doneNack;
		rxData = doneData;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_defaults;
		for (int i = 0; i < REG_COUNT; i++)
			check(cfgRegs[8*i +: 8], CIRS_REG_DEFAULTS[8*i +: 8]);
	endtask

	// Boundary indices and one mid-file index, the first one past the file included
	task t_writeRead(input logic pin);
		logic [7:0] idx;
		logic [7:0] d;
		logic tog;
		addrSelectPin = pin;
		for (int i = 0; i < 4; i++) begin
			idx = IDX_TAB[i];
			d = idx ^ {pin, 7'h35};
			tog = cfgWriteToggle;
			xfer(DIR_WRITE, {CIRS_ADDR_HIGH, pin}, idx, d);
			check({7'h00, rxNack}, 8'h00);
			// Three nine-bit slots may not beat the top bit rate
			check({7'h00, busyCycles >= 27 * CLK_HZ / (LINK_RATE_KBPS * 1000)}, 8'h01);
			if (idx <= REG_LAST_INDEX) begin
				check(cfgRegs[8*idx +: 8], d);
				check({7'h00, cfgWriteToggle}, {7'h00, ~tog});
			end else begin
				check({7'h00, cfgWriteToggle}, {7'h00, tog});
			end
			xfer(DIR_READ, {CIRS_ADDR_HIGH, pin}, idx, 8'h00);
			check({7'h00, rxNack}, 8'h00);
			check(rxData, (idx <= REG_LAST_INDEX) ? d : 8'h00);
		end
	endtask

	task t_addrMiss;
		logic [6:0] bad [3];
		logic [7:0] old;
		logic tog;
		bad = '{{CIRS_ADDR_HIGH, 1'b0}, {6'h09, 1'b1}, {6'h28, 1'b1}};
		addrSelectPin = 1'b1;
		old = cfgRegs[8*16 +: 8];
		tog = cfgWriteToggle;
		for (int i = 0; i < 3; i++) begin
			xfer(i[0], bad[i], 8'h10, 8'ha5);
			check({7'h00, rxNack}, 8'h01);
		end
		check(cfgRegs[8*16 +: 8], old);
		check({7'h00, cfgWriteToggle}, {7'h00, tog});
		xfer(DIR_WRITE, {CIRS_ADDR_HIGH, 1'b1}, 8'h10, 8'h5a);
		check(cfgRegs[8*16 +: 8], 8'h5a);
	endtask

	// Reset cuts a write mid-address; the next start must be seen cleanly
	task t_midReset;
		@(negedge clk);
		reqValid = 1'b1;
		reqRead = DIR_WRITE;
		reqSlave = {CIRS_ADDR_HIGH, 1'b1};
		reqIndex = 8'h2a;
		reqData = 8'h00;
		@(negedge clk);
		reqValid = 1'b0;
		repeat (300) @(negedge clk);
		resetn = 1'b0;
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		check(cfgRegs[8*42 +: 8], CIRS_REG_DEFAULTS[8*42 +: 8]);
		xfer(DIR_READ, {CIRS_ADDR_HIGH, 1'b1}, 8'h4e, 8'h00);
		check(rxData, CIRS_REG_DEFAULTS[8*78 +: 8]);
	endtask

	initial begin
		@(negedge clk);
		resetn = 1'b0;
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		t_defaults();
		t_writeRead(1'b0);
		t_writeRead(1'b1);
		t_addrMiss();
		t_midReset();
		endOfTest();
	end
endmodule
